/* File: src/xint_pkg.sv */
// Constants for the extended interrupt unit: special-function register
// addresses, field positions, reset values, ranks and vectors.
// Shared by the edge detector, the arbiter and the top module.
package xint_pkg;
  localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_STD_EN = 8'ha8;
  localparam logic [7:0] ADDR_STD_PRI = 8'hb8;
  localparam logic [7:0] ADDR_WAKE_CTL = 8'hd8;
  localparam logic [7:0] ADDR_EXT_EN = 8'he8;
  localparam logic [7:0] ADDR_EXT_PRI = 8'hf8;
  // Reserved bits that read as one
  localparam logic [7:0] STD_PRI_FIXED_ONES = 8'h80;
  localparam logic [7:0] EXT_FLAGS_FIXED_ONES = 8'h08;
  localparam logic [7:0] WAKE_CTL_FIXED_ONES = 8'h40;
  localparam logic [7:0] EXT_EN_FIXED_ONES = 8'he0;
  localparam logic [7:0] EXT_PRI_FIXED_ONES = 8'he0;
  // Field positions
  localparam int GLOBAL_GATE_BIT = 7;
  localparam int SERIAL1_BIT = 6;
  localparam int PIN5_FLAG_BIT = 7;
  localparam int PIN4_FLAG_BIT = 6;
  localparam int TWOWIRE_FLAG_BIT = 5;
  localparam int USB_FLAG_BIT = 4;
  localparam int BAUD_DOUBLE_BIT = 7;
  localparam int RESUME_ON_BIT = 5;
  localparam int WAKEUP_FLAG_BIT = 4;
  localparam int PIN6_FLAG_BIT = 3;
  // Reset values
  localparam logic [6:0] STD_RESET = 7'h00;
  localparam logic [4:0] EXT_RESET = 5'h00;
  // Sources in natural rank order, 0 is best
  localparam int NUM_SRC = 13;
  localparam int SRC_RESUME = 0;
  localparam int SRC_PIN0 = 1;
  localparam int SRC_TIMER0 = 2;
  localparam int SRC_PIN1 = 3;
  localparam int SRC_TIMER1 = 4;
  localparam int SRC_SERIAL0 = 5;
  localparam int SRC_TIMER2 = 6;
  localparam int SRC_SERIAL1 = 7;
  localparam int SRC_USB = 8;
  localparam int SRC_TWOWIRE = 9;
  localparam int SRC_PIN4 = 10;
  localparam int SRC_PIN5 = 11;
  localparam int SRC_PIN6 = 12;
  localparam logic [3:0] NO_SRC = 4'hf;
  localparam logic [7:0] VECTOR_TABLE [NUM_SRC] = '{
    8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
    8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
  // Service levels on the nesting stack
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_TOP = 2'h2;
  localparam logic [1:0] LVL_IDLE = 2'h3;
  // Instructions the core must finish before a grant
  localparam logic [1:0] HOLD_NONE = 2'h0;
  localparam logic [1:0] HOLD_ONE = 2'h1;
  localparam logic [1:0] HOLD_TWO = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_OFFER = 2'b01,
    ST_WAIT_ACK = 2'b11
  } grant_state_type;
endpackage

/* File: src/xint_edge.sv */
// Two-flop synchroniser followed by an edge detector for one pin.
// Assumes the pin is asynchronous to clock_in.
module xint_edge
  import xint_pkg::*;
#(
  parameter bit RISING = 1'b1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Pin and result
  input wire logic pin_in,
  output logic level_out,
  output logic edge_out
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic edge_seen;
  } edge_state_type;

  edge_state_type state_r;
  edge_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = pin_in;
    state_nxt.sync = state_r.meta;
    state_nxt.prev = state_r.sync;
    state_nxt.edge_seen = RISING ? (state_r.sync & ~state_r.prev)
                                 : (~state_r.sync & state_r.prev);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '{meta: 1'b1 ^ RISING, sync: 1'b1 ^ RISING,
                   prev: 1'b1 ^ RISING, edge_seen: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign level_out = state_r.sync;
  assign edge_out = state_r.edge_seen;
endmodule

/* File: src/xint_arbiter.sv */
// Picks the request to grant: level first, then natural rank.
// Pure combinational; the top registers its result.
module xint_arbiter
  import xint_pkg::*;
(
  // Requests
  input wire logic [NUM_SRC-1:0] req_in,
  input wire logic [NUM_SRC-1:0] high_in,
  input wire logic [1:0] active_level_in,
  // Choice
  output logic valid_out,
  output logic [3:0] src_out,
  output logic [1:0] level_out
);
  function automatic logic [1:0] level_of(input int idx, input logic hi);
    if (idx == SRC_RESUME) begin
      return LVL_TOP;
    end
    return hi ? LVL_HIGH : LVL_LOW;
  endfunction

  always_comb begin
    logic [1:0] lvl;
    lvl = LVL_LOW;
    valid_out = 1'b0;
    src_out = NO_SRC;
    level_out = LVL_LOW;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      lvl = level_of(i, high_in[i]);
      // Strictly above the running level; lower index wins ties
      if (req_in[i] && (active_level_in == LVL_IDLE || lvl > active_level_in)
          && (!valid_out || lvl >= level_out)) begin
        valid_out = 1'b1;
        src_out = 4'(i);
        level_out = lvl;
      end
    end
  end
endmodule

/* File: src/xint_unit.sv */
// Extended interrupt unit: the six interrupt registers on the special
// function bus, pin edge capture, arbitration and vector hand-off.
// Assumes the core gives one-cycle sfr strobes, an instruction-end
// pulse, an acknowledge when it takes the vector and a return pulse.
// Notes on behaviour
// (RQ1) Global gate off masks all sources except resume; on, each own enable.
// (RQ2) Serial 1 enable and level bits work only when extended unit present.
// (RQ3) Bits of absent serial 0, serial 1, timer 2 stored but ignored.
// (RQ4) Standard enables bits 0-6: pin0, t0, pin1, t1, serial0, t2, serial1.
// (RQ5) Standard levels bits 0-6 same order; 1 means high.
// (RQ6) Reserved bits read fixed ones or zeros as laid out.
// (RQ7) Pin 5 flag sets on falling edge, cleared only by software.
// (RQ8) Pin 4 flag sets on rising edge, cleared only by software.
// (RQ9) Two-wire flag sets on controller request, cleared by software.
// (RQ10) USB flag sets on engine request, cleared by software.
// (RQ11) Software writing one to an extended flag requests like hardware.
// (RQ12) Wake control bit 7 drives serial 1 baud doubling.
// (RQ13) Resume request gated by its own enable bit.
// (RQ14) Wakeup flag sets on wake pin fall or USB resume.
// (RQ15) Software clears wakeup flag before return, else it re-requests.
// (RQ16) Pin 6 flag sets on rising edge, cleared by writing zero.
// (RQ17) Extended enables bits 0-4: usb, two-wire, pin4, pin5, pin6.
// (RQ18) Extended levels bits 0-4 same order; 1 means high.
// (RQ19) Accepted request passes its vector to the core.
// (RQ20) Low service preempted only by strictly higher level.
// (RQ21) High service preempted only by resume.
// (RQ22) Finish current instruction; one more after return or enable writes.
// (RQ23) Return pops nesting so the core resumes where it left.
// (RQ24) Fixed rank and vector per source, resume rank 0 at 33h.
// (RQ25) Same level resolved by natural rank; level beats rank.
// (RQ26) Pins 4-6 edge only; pin 5 active low. USB and two-wire flags are set by the request level, not an edge.
// (RQ27) Pins 0 and 1 active low, level or edge by type bit.
// (RQ28) Hardware set beats a software clear in the same cycle.
// (RQ29) Enables, levels and flags clear at reset.
module xint_unit
  import xint_pkg::*;
#(
  parameter bit EXT_UNIT_PRESENT = 1'b1,
  parameter bit SERIAL0_PRESENT = 1'b1,
  parameter bit SERIAL1_PRESENT = 1'b1,
  parameter bit TIMER2_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Special function register bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Pins, active low where named so
  input wire logic pin0_n_in,
  input wire logic pin1_n_in,
  input wire logic pin4_in,
  input wire logic pin5_n_in,
  input wire logic pin6_in,
  input wire logic wakeup_n_in,
  // Pin 0/1 type selects and on-chip sources
  input wire logic pin0_type_select_in,
  input wire logic pin1_type_select_in,
  input wire logic timer0_flag_in,
  input wire logic timer1_flag_in,
  input wire logic serial0_flag_in,
  input wire logic timer2_flag_in,
  input wire logic serial1_flag_in,
  input wire logic usb_engine_req_in,
  input wire logic twowire_req_in,
  input wire logic usb_resume_in,
  // Core handshake, pin 0/1 events and serial 1 baud doubling
  input wire logic instr_done_in,
  input wire logic return_from_service_in,
  input wire logic vector_ack_in,
  output logic irq_req_out,
  output logic [7:0] irq_vector_out,
  output logic pin0_event_out,
  output logic pin1_event_out,
  output logic serial1_baud_double_out
);
  typedef struct packed {
    logic [7:0] std_en;
    logic [6:0] std_pri;
    logic [3:0] ext_flags;
    logic baud_double;
    logic resume_on;
    logic wake_flag;
    logic pin6_flag;
    logic [4:0] ext_en;
    logic [4:0] ext_pri;
    logic [7:0] rdata;
    logic [1:0] hold;
    grant_state_type gstate;
    logic [3:0] gsrc;
    logic [1:0] glevel;
    logic [1:0] sp;
    logic [5:0] stack;
    logic req;
    logic [7:0] vector;
    logic pin0_ev;
    logic pin1_ev;
    logic [1:0] pin_prev_n;
  } unit_state_type;

  unit_state_type state_r;
  unit_state_type state_nxt;

  logic p0_lvl, p1_lvl, p4_edge, p5_edge, p6_edge, wake_edge;
  logic arb_valid;
  logic [3:0] arb_src;
  logic [1:0] arb_level;
  logic [1:0] active_level;
  logic [NUM_SRC-1:0] reqs;
  logic [NUM_SRC-1:0] highs;

  xint_edge #(.RISING(1'b0)) u_p0 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(pin0_n_in), .level_out(p0_lvl), .edge_out());
  xint_edge #(.RISING(1'b0)) u_p1 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(pin1_n_in), .level_out(p1_lvl), .edge_out());
  // (RQ26) Edge only capture
  xint_edge #(.RISING(1'b1)) u_p4 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(pin4_in), .level_out(), .edge_out(p4_edge));
  xint_edge #(.RISING(1'b0)) u_p5 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(pin5_n_in), .level_out(), .edge_out(p5_edge));
  xint_edge #(.RISING(1'b1)) u_p6 (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(pin6_in), .level_out(), .edge_out(p6_edge));
  xint_edge #(.RISING(1'b0)) u_wk (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(wakeup_n_in), .level_out(), .edge_out(wake_edge));

  function automatic logic flag_next(input logic cur, input logic hw,
                                     input logic wr, input logic wbit);
    // (RQ28) Set beats clear
    return hw | (wr ? wbit : cur);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                               input logic wr);
    return wr && (a == b);
  endfunction

  always_comb begin
    logic s1_ok, gate;
    s1_ok = EXT_UNIT_PRESENT & SERIAL1_PRESENT;
    gate = state_r.std_en[GLOBAL_GATE_BIT];
    reqs = '0;
    // (RQ1) Global gate; (RQ3) absent modules ignored
    reqs[SRC_PIN0] = gate & state_r.std_en[0] & state_r.pin0_ev;
    reqs[SRC_TIMER0] = gate & state_r.std_en[1] & timer0_flag_in;
    reqs[SRC_PIN1] = gate & state_r.std_en[2] & state_r.pin1_ev;
    reqs[SRC_TIMER1] = gate & state_r.std_en[3] & timer1_flag_in;
    reqs[SRC_SERIAL0] = gate & state_r.std_en[4] & serial0_flag_in & SERIAL0_PRESENT;
    reqs[SRC_TIMER2] = gate & state_r.std_en[5] & timer2_flag_in & TIMER2_PRESENT;
    // (RQ2) Serial 1 only with extended unit
    reqs[SRC_SERIAL1] = gate & state_r.std_en[6] & serial1_flag_in & s1_ok;
    // (RQ11) Flag bits request whatever set them
    reqs[SRC_USB] = gate & state_r.ext_en[0] & state_r.ext_flags[0];
    reqs[SRC_TWOWIRE] = gate & state_r.ext_en[1] & state_r.ext_flags[1];
    reqs[SRC_PIN4] = gate & state_r.ext_en[2] & state_r.ext_flags[2];
    reqs[SRC_PIN5] = gate & state_r.ext_en[3] & state_r.ext_flags[3];
    reqs[SRC_PIN6] = gate & state_r.ext_en[4] & state_r.pin6_flag;
    // (RQ13) Resume gated only by its own enable; (RQ15) flag re-requests
    reqs[SRC_RESUME] = state_r.resume_on & state_r.wake_flag;
    highs = '0;
    highs[6:1] = state_r.std_pri[5:0];
    highs[SRC_SERIAL1] = state_r.std_pri[6] & s1_ok;
    highs[12:8] = state_r.ext_pri;
    active_level = (state_r.sp == 2'd0) ? LVL_IDLE
                 : state_r.stack[2*(state_r.sp-2'd1) +: 2];
  end

  // (RQ20) (RQ21) (RQ25) Level then rank
  xint_arbiter u_arb (.req_in(reqs), .high_in(highs),
    .active_level_in(active_level), .valid_out(arb_valid),
    .src_out(arb_src), .level_out(arb_level));

  always_comb begin
    logic wa, wb, wc, wd, we, wf;
    state_nxt = state_r;
    wa = hit(sfr_addr_in, ADDR_STD_EN, sfr_wr_in);
    wb = hit(sfr_addr_in, ADDR_STD_PRI, sfr_wr_in);
    wc = hit(sfr_addr_in, ADDR_EXT_FLAGS, sfr_wr_in);
    wd = hit(sfr_addr_in, ADDR_WAKE_CTL, sfr_wr_in);
    we = hit(sfr_addr_in, ADDR_EXT_EN, sfr_wr_in);
    wf = hit(sfr_addr_in, ADDR_EXT_PRI, sfr_wr_in);
    // (RQ4) Standard enable layout
    if (wa) begin
      state_nxt.std_en = sfr_wdata_in;
    end
    // (RQ5) Standard level layout
    if (wb) begin
      state_nxt.std_pri = sfr_wdata_in[6:0];
    end
    // (RQ2) Serial 1 bits held zero without the extended unit
    if (!EXT_UNIT_PRESENT) begin
      state_nxt.std_en[SERIAL1_BIT] = 1'b0;
      state_nxt.std_pri[SERIAL1_BIT] = 1'b0;
    end
    // (RQ7) (RQ8) (RQ9) (RQ10) Sticky flags
    state_nxt.ext_flags[3] = flag_next(state_r.ext_flags[3], p5_edge, wc,
                                       sfr_wdata_in[PIN5_FLAG_BIT]);
    state_nxt.ext_flags[2] = flag_next(state_r.ext_flags[2], p4_edge, wc,
                                       sfr_wdata_in[PIN4_FLAG_BIT]);
    state_nxt.ext_flags[1] = flag_next(state_r.ext_flags[1], twowire_req_in, wc,
                                       sfr_wdata_in[TWOWIRE_FLAG_BIT]);
    state_nxt.ext_flags[0] = flag_next(state_r.ext_flags[0], usb_engine_req_in, wc,
                                       sfr_wdata_in[USB_FLAG_BIT]);
    // (RQ12) Baud doubling control
    if (wd) begin
      state_nxt.baud_double = sfr_wdata_in[BAUD_DOUBLE_BIT];
      state_nxt.resume_on = sfr_wdata_in[RESUME_ON_BIT];
    end
    // (RQ14) Wakeup sources
    state_nxt.wake_flag = flag_next(state_r.wake_flag, wake_edge | usb_resume_in,
                                    wd, sfr_wdata_in[WAKEUP_FLAG_BIT]);
    // (RQ16) Pin 6 flag
    state_nxt.pin6_flag = flag_next(state_r.pin6_flag, p6_edge, wd,
                                    sfr_wdata_in[PIN6_FLAG_BIT]);
    // (RQ17) Extended enable layout
    if (we) begin
      state_nxt.ext_en = sfr_wdata_in[4:0];
    end
    // (RQ18) Extended level layout
    if (wf) begin
      state_nxt.ext_pri = sfr_wdata_in[4:0];
    end
    // (RQ27) Level or high-then-low on consecutive samples
    state_nxt.pin_prev_n = {p1_lvl, p0_lvl};
    state_nxt.pin0_ev = pin0_type_select_in ? (state_r.pin_prev_n[0] & ~p0_lvl)
                                            : ~p0_lvl;
    state_nxt.pin1_ev = pin1_type_select_in ? (state_r.pin_prev_n[1] & ~p1_lvl)
                                            : ~p1_lvl;
    // (RQ6) Reads with fixed reserved bits
    state_nxt.rdata = 8'h00;
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        ADDR_STD_EN: state_nxt.rdata = state_r.std_en;
        ADDR_STD_PRI: state_nxt.rdata = STD_PRI_FIXED_ONES | {1'b0, state_r.std_pri};
        ADDR_EXT_FLAGS: state_nxt.rdata = EXT_FLAGS_FIXED_ONES
                                        | {state_r.ext_flags, 4'h0};
        ADDR_WAKE_CTL: state_nxt.rdata = WAKE_CTL_FIXED_ONES
            | {state_r.baud_double, 1'b0, state_r.resume_on, state_r.wake_flag,
               state_r.pin6_flag, 3'h0};
        ADDR_EXT_EN: state_nxt.rdata = EXT_EN_FIXED_ONES | {3'h0, state_r.ext_en};
        ADDR_EXT_PRI: state_nxt.rdata = EXT_PRI_FIXED_ONES | {3'h0, state_r.ext_pri};
        default: state_nxt.rdata = 8'h00;
      endcase
    end
    // (RQ22) Extra instruction after a return or enable/level write
    if (return_from_service_in || wa || wb || we || wf) begin
      state_nxt.hold = HOLD_TWO;
    end else if (instr_done_in && state_r.hold != HOLD_NONE) begin
      state_nxt.hold = state_r.hold - HOLD_ONE;
    end
    // (RQ23) Return pops the nesting level
    if (return_from_service_in && state_r.sp != 2'd0) begin
      state_nxt.sp = state_r.sp - 2'd1;
    end
    case (state_r.gstate)
      ST_RUN: begin
        if (arb_valid && instr_done_in && state_r.hold <= HOLD_ONE
            && !return_from_service_in) begin
          state_nxt.gstate = ST_OFFER;
          state_nxt.gsrc = arb_src;
          state_nxt.glevel = arb_level;
        end
      end
      ST_OFFER: begin
        // (RQ19) (RQ24) Vector from fixed table
        state_nxt.req = 1'b1;
        state_nxt.vector = VECTOR_TABLE[state_r.gsrc];
        state_nxt.gstate = ST_WAIT_ACK;
      end
      ST_WAIT_ACK: begin
        if (vector_ack_in) begin
          state_nxt.req = 1'b0;
          state_nxt.gstate = ST_RUN;
          state_nxt.stack[2*state_r.sp +: 2] = state_r.glevel;
          state_nxt.sp = state_r.sp + 2'd1;
        end
      end
      default: state_nxt.gstate = ST_RUN;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      // (RQ29) All clear except pin_prev_n, which loads ones
      state_r <= '{std_en: 8'h00, std_pri: STD_RESET, ext_flags: 4'h0,
                   baud_double: 1'b0, resume_on: 1'b0, wake_flag: 1'b0,
                   pin6_flag: 1'b0, ext_en: EXT_RESET, ext_pri: EXT_RESET,
                   rdata: 8'h00, hold: HOLD_NONE, gstate: ST_RUN, gsrc: 4'h0,
                   glevel: LVL_LOW, sp: 2'd0, stack: 6'h00, req: 1'b0,
                   vector: 8'h00, pin0_ev: 1'b0, pin1_ev: 1'b0,
                   pin_prev_n: 2'b11};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sfr_rdata_out = state_r.rdata;
  assign irq_req_out = state_r.req;
  assign irq_vector_out = state_r.vector;
  assign pin0_event_out = state_r.pin0_ev;
  assign pin1_event_out = state_r.pin1_ev;
  assign serial1_baud_double_out = state_r.baud_double;

  // (RQ28) Hardware set survives a same-cycle clear
  AST_SET_WINS: assert property (@(posedge clock_in) disable iff (rst_in) // RQ28
    usb_engine_req_in |=> state_r.ext_flags[0]) else $error("usb flag lost");
  AST_PIN6_STICKY: assert property (@(posedge clock_in) disable iff (rst_in) // RQ16
    state_r.pin6_flag && !hit(sfr_addr_in, ADDR_WAKE_CTL, sfr_wr_in)
    |=> state_r.pin6_flag) else $error("pin6 flag dropped");
  AST_GATE_MASK: assert property (@(posedge clock_in) disable iff (rst_in) // RQ1
    !state_r.std_en[GLOBAL_GATE_BIT] |-> reqs[12:1] == '0) else $error("gate leak");
  AST_RESUME_GATE: assert property (@(posedge clock_in) disable iff (rst_in) // RQ13
    !state_r.resume_on |-> !reqs[SRC_RESUME]) else $error("resume leak");
  AST_VECTOR: assert property (@(posedge clock_in) disable iff (rst_in) // RQ19
    state_r.gstate == ST_OFFER |=> irq_req_out
    && irq_vector_out == VECTOR_TABLE[$past(state_r.gsrc)]) else $error("bad vector");
  AST_HIGH_NEST: assert property (@(posedge clock_in) disable iff (rst_in) // RQ21
    active_level == LVL_HIGH && arb_valid |-> arb_src == 4'(SRC_RESUME))
    else $error("high preempted");
  AST_STRICT: assert property (@(posedge clock_in) disable iff (rst_in) // RQ20
    arb_valid && active_level != LVL_IDLE |-> arb_level > active_level)
    else $error("same level preempt");
  AST_HOLD: assert property (@(posedge clock_in) disable iff (rst_in) // RQ22
    return_from_service_in |=> state_r.gstate != ST_OFFER ##1 state_r.gstate != ST_OFFER)
    else $error("early grant");
  AST_RESERVED: assert property (@(posedge clock_in) disable iff (rst_in) // RQ6
    sfr_rd_in && sfr_addr_in == ADDR_EXT_EN |=> sfr_rdata_out[7:5] == 3'h7)
    else $error("reserved bits");
endmodule

/* File: bench/xint_core_model.sv */
// Behavioural processor core facing the interrupt unit.
// Assumes the bench picks the acknowledge delay and drives returns itself.
module xint_core_model (
  // Clock
  input wire logic clock_in,
  // From the unit and the bench
  input wire logic irq_req_in,
  input wire logic [3:0] ack_delay_in,
  // To the unit
  output logic instr_done_out,
  output logic vector_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  initial begin
    instr_done_out = 1'b0;
    vector_ack_out = 1'b0;
    wait_cnt = 0;
  end
  // Single-cycle instructions keep the grant path busiest
  always @(negedge clock_in) begin
    instr_done_out <= 1'b1;
    vector_ack_out <= 1'b0;
    if (irq_req_in && !vector_ack_out) begin
      // A shorter delay picked mid-wait must not stall the acknowledge
      if (wait_cnt >= int'(ack_delay_in)) begin
        vector_ack_out <= 1'b1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

/* File: bench/extended_interrupt_unit_tb.sv */
// Self-checking bench for the extended interrupt unit.
// Assumes the core model answers vectors; bench drives registers and pins.
module extended_interrupt_unit_tb
  import xint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_in, sfr_wr_in, sfr_rd_in, pin0_n_in, pin1_n_in, pin4_in, pin5_n_in;
  logic pin6_in, wakeup_n_in, pin0_type_select_in, pin1_type_select_in, timer0_flag_in;
  logic timer1_flag_in, serial0_flag_in, timer2_flag_in, serial1_flag_in, usb_engine_req_in;
  logic twowire_req_in, usb_resume_in, instr_done_in, return_from_service_in, vector_ack_in;
  logic irq_req_out, pin0_event_out, pin1_event_out, serial1_baud_double_out, rd_d, req_d;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, irq_vector_out, d;
  logic [3:0] ack_delay;
  logic [7:0] rq[$];
  logic [7:0] vq[$];
  int fail_count, num_checks;
  localparam logic [7:0] ADDRS [6] = '{ADDR_EXT_FLAGS, ADDR_STD_EN, ADDR_STD_PRI,
    ADDR_WAKE_CTL, ADDR_EXT_EN, ADDR_EXT_PRI};
  localparam logic [7:0] ONES [6] = '{EXT_FLAGS_FIXED_ONES, 8'h00, STD_PRI_FIXED_ONES,
    WAKE_CTL_FIXED_ONES, EXT_EN_FIXED_ONES, EXT_PRI_FIXED_ONES};
  // Gate and resume enable kept off so random writes raise no request
  localparam logic [7:0] WMASK [6] = '{8'hf0, 8'h7f, 8'h7f, 8'h98, 8'h1f, 8'h1f};
  localparam logic [7:0] EV_BIT [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08};

  xint_unit xint_unit_i (.clock_in, .rst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
    .sfr_rd_in, .sfr_rdata_out, .pin0_n_in, .pin1_n_in, .pin4_in, .pin5_n_in, .pin6_in,
    .wakeup_n_in, .pin0_type_select_in, .pin1_type_select_in, .timer0_flag_in,
    .timer1_flag_in, .serial0_flag_in, .timer2_flag_in, .serial1_flag_in,
    .usb_engine_req_in, .twowire_req_in, .usb_resume_in, .instr_done_in,
    .return_from_service_in, .vector_ack_in, .irq_req_out, .irq_vector_out,
    .pin0_event_out, .pin1_event_out, .serial1_baud_double_out);
  xint_core_model xint_core_model_i (.clock_in(clock_in), .irq_req_in(irq_req_out),
    .ack_delay_in(ack_delay), .instr_done_out(instr_done_in),
    .vector_ack_out(vector_ack_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_in);
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    @(negedge clock_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    rq.push_back(e);
    @(negedge clock_in);
    sfr_rd_in = 1'b0;
  endtask
  task automatic take(input logic [7:0] v);
    int n;
    vq.push_back(v);
    ack_delay = 4'($urandom_range(0, 7));
    n = 0;
    while (vector_ack_in !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    if (vector_ack_in !== 1'b1) fail_count++;
    @(negedge clock_in);
  endtask
  task automatic ret();
    @(negedge clock_in);
    return_from_service_in = 1'b1;
    @(negedge clock_in);
    return_from_service_in = 1'b0;
  endtask
  task automatic quiet();
    repeat (8) begin
      @(negedge clock_in);
      check({7'h00, irq_req_out}, 8'h00);
    end
  endtask
  task automatic idle();
    pin4_in = 1'b0;
    pin6_in = 1'b0;
    pin5_n_in = 1'b1;
    wakeup_n_in = 1'b1;
    usb_engine_req_in = 1'b0;
    twowire_req_in = 1'b0;
    usb_resume_in = 1'b0;
  endtask

  // Results are compared in the order they were expected
  always @(posedge clock_in) rd_d <= sfr_rd_in;
  always @(negedge clock_in) begin
    if (rd_d) check(sfr_rdata_out, rq.pop_front());
    if (irq_req_out && !req_d) begin
      check(irq_vector_out, vq.size() != 0 ? vq.pop_front() : 8'hxx);
    end
    req_d = irq_req_out;
  end

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    #25000;
    fail_count++;
    final_report();
  end

  initial begin
    {sfr_wr_in, sfr_rd_in, timer0_flag_in, timer1_flag_in, serial0_flag_in} = '0;
    {timer2_flag_in, serial1_flag_in, return_from_service_in, rd_d, req_d} = '0;
    {pin0_type_select_in, pin1_type_select_in, sfr_addr_in, sfr_wdata_in} = '0;
    {pin0_n_in, pin1_n_in} = 2'b11;
    ack_delay = 4'h0;
    fail_count = 0;
    num_checks = 0;
    idle();
    rst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    void'($urandom(72287));
    for (int i = 0; i < 6; i++) rd(ADDRS[i], ONES[i]);
    rd(8'h90, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom()) & WMASK[i];
      wr(ADDRS[i], d);
      rd(ADDRS[i], d | ONES[i]);
      if (i == 3) check({7'h00, serial1_baud_double_out}, {7'h00, d[7]});
    end
    for (int i = 0; i < 6; i++) wr(ADDRS[i], 8'h00);
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: pin5_n_in = 1'b0;
        1: pin4_in = 1'b1;
        2: twowire_req_in = 1'b1;
        3: usb_engine_req_in = 1'b1;
        4: wakeup_n_in = 1'b0;
        5: usb_resume_in = 1'b1;
        default: pin6_in = 1'b1;
      endcase
      repeat (4) @(negedge clock_in);
      idle();
      repeat (6) @(negedge clock_in);
      rd(ADDRS[k < 4 ? 0 : 3], EV_BIT[k] | ONES[k < 4 ? 0 : 3]);
      wr(ADDRS[k < 4 ? 0 : 3], 8'h00);
    end
    // Request held across a clearing write must survive
    twowire_req_in = 1'b1;
    wr(ADDR_EXT_FLAGS, 8'h00);
    twowire_req_in = 1'b0;
    rd(ADDR_EXT_FLAGS, 8'h28);
    wr(ADDR_EXT_FLAGS, 8'h00);
    pin0_n_in = 1'b0;
    repeat (5) @(negedge clock_in);
    check({7'h00, pin0_event_out}, 8'h01);
    pin0_n_in = 1'b1;
    // Edge mode gives exactly one event per fall
    pin1_type_select_in = 1'b1;
    pin1_n_in = 1'b0;
    d = 8'h00;
    repeat (6) begin
      @(negedge clock_in);
      d = d + {7'h00, pin1_event_out};
    end
    check(d, 8'h01);
    pin1_n_in = 1'b1;
    wr(ADDR_STD_EN, 8'h82);
    timer0_flag_in = 1'b1;
    take(8'h0b);
    timer0_flag_in = 1'b0;
    ret();
    wr(ADDR_EXT_EN, 8'h03);
    wr(ADDR_EXT_FLAGS, 8'h30);
    take(8'h43);
    quiet();
    wr(ADDR_EXT_FLAGS, 8'h20);
    ret();
    take(8'h4b);
    wr(ADDR_EXT_FLAGS, 8'h00);
    ret();
    wr(ADDR_EXT_PRI, 8'h02);
    wr(ADDR_EXT_FLAGS, 8'h30);
    take(8'h4b);
    quiet();
    wr(ADDR_WAKE_CTL, 8'h30);
    take(8'h33);
    wr(ADDR_WAKE_CTL, 8'h00);
    ret();
    wr(ADDR_EXT_FLAGS, 8'h10);
    ret();
    take(8'h43);
    wr(ADDR_STD_EN, 8'h00);
    ret();
    quiet();
    wr(ADDR_WAKE_CTL, 8'h10);
    quiet();
    wr(ADDR_WAKE_CTL, 8'h30);
    take(8'h33);
    wr(ADDR_WAKE_CTL, 8'h00);
    ret();
    repeat (4) @(negedge clock_in);
    final_report();
  end
endmodule
